// ===== inc/psl_defs.svh
// psl_defs.svh: register offsets, field positions, reset values, counts
// assumes one byte register per address on a 16-bit register port
`ifndef PSL_DEFS_SVH
`define PSL_DEFS_SVH
`define PSL_ADDR_W      16
`define PSL_LOCK_OFS    16'h1E8F
`define PSL_IN_INT      16'h1E90
`define PSL_IN_T0CK     16'h1E91
`define PSL_IN_T1CK     16'h1E92
`define PSL_IN_T1G      16'h1E93
`define PSL_IN_T3CK     16'h1E94
`define PSL_IN_T3G      16'h1E95
`define PSL_IN_T5CK     16'h1E96
`define PSL_IN_T5G      16'h1E97
`define PSL_IN_T2EXT    16'h1E9C
`define PSL_IN_T4EXT    16'h1E9D
`define PSL_IN_T6EXT    16'h1E9E
`define PSL_IN_CAP1     16'h1EA1
`define PSL_IN_CAP2     16'h1EA2
`define PSL_IN_CAP3     16'h1EA3
`define PSL_IN_CAP4     16'h1EA4
`define PSL_IN_MTWIN    16'h1EA9
`define PSL_IN_MTSIG    16'h1EAA
`define PSL_IN_WAVE1    16'h1EB1
`define PSL_IN_WAVE2    16'h1EB2
`define PSL_IN_MODCL    16'h1EB8
`define PSL_IN_MODCH    16'h1EB9
`define PSL_IN_MODSRC   16'h1EBA
`define PSL_IN_LC0      16'h1EBB
`define PSL_IN_LC1      16'h1EBC
`define PSL_IN_LC2      16'h1EBD
`define PSL_IN_LC3      16'h1EBE
`define PSL_IN_ADTRG    16'h1EC3
`define PSL_IN_SPCLK    16'h1EC5
`define PSL_IN_SPDAT    16'h1EC6
`define PSL_IN_SPCS     16'h1EC7
`define PSL_IN_CNT      30
`define PSL_OUT_BASE    16'h1F10
`define PSL_OUT_CNT     24
`define PSL_OUT_MASK_LG 24'hFFF037
`define PSL_OUT_MASK_SM 24'h3F0037
`define PSL_KEY1        8'h55
`define PSL_KEY2        8'hAA
`define PSL_LOCK_BIT    0
`define PSL_PIN_LSB     0
`define PSL_PIN_W       3
`define PSL_PORT_LSB    3
`define PSL_PORT_W      2
`define PSL_PORT_NONE   2'h3
`define PSL_SRC_W       6
`define PSL_LOCK_RST    1'h0
`define PSL_IN_RST      5'h00
`define PSL_OUT_RST     6'h00
`define PSL_CFG_WAIT    2'h3
`endif

// ===== inc/psl_pkg.sv
// psl_pkg: types shared by the pin routing lock control
// assumes psl_defs.svh supplies the field widths
`include "psl_defs.svh"
package psl_pkg;
  // progress through the two-key unlock sequence
  typedef enum logic [1:0] {
    PSL_KEY_IDLE,
    PSL_KEY_HALF,
    PSL_KEY_OPEN
  } psl_key_t;
  typedef logic [`PSL_PORT_W+`PSL_PIN_W-1:0] psl_insel_t;
  typedef logic [`PSL_SRC_W-1:0]             psl_outsel_t;
endpackage

// ===== verilog/psl_lock_ctrl.sv
// psl_lock_ctrl: pin routing crossbar with selection lock and key unlock
// assumes a byte register port on clk, pins asynchronous to clk,
// rst is the power-on reset and sys_reset any other device reset
`timescale 1ns/100ps
`include "psl_defs.svh"

module psl_lock_ctrl
  import psl_pkg::*;
#(
  parameter bit                   LARGE_PKG   = 1'b1,
  parameter logic [`PSL_IN_CNT*5-1:0] IN_DEFAULT = '0
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   sys_reset,
  input  wire logic                   sleep,
  input  wire logic                   one_way_pin,
  input  wire logic [`PSL_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wr_data,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic [23:0]            pin_in,
  input  wire logic [63:0]            periph_src,
  output logic [7:0]                  rd_data_reg,
  output logic                        lock_flag_reg,
  output logic                        one_way_reg,
  output logic                        used_reg,
  output logic [`PSL_IN_CNT-1:0]      periph_in_reg,
  output logic [`PSL_OUT_CNT-1:0]     pin_out_reg,
  output logic [`PSL_OUT_CNT-1:0]     pin_out_en_reg
);

  localparam int NIN  = `PSL_IN_CNT;
  localparam int NOUT = `PSL_OUT_CNT;

  // present output selects depend on the package variant
  localparam logic [NOUT-1:0] OUT_PRESENT =
    LARGE_PKG ? `PSL_OUT_MASK_LG : `PSL_OUT_MASK_SM;

  // offset of each input select, in register order
  localparam logic [`PSL_ADDR_W-1:0] IN_OFS [NIN] = '{
    `PSL_IN_INT,   `PSL_IN_T0CK,  `PSL_IN_T1CK,  `PSL_IN_T1G,
    `PSL_IN_T3CK,  `PSL_IN_T3G,   `PSL_IN_T5CK,  `PSL_IN_T5G,
    `PSL_IN_T2EXT, `PSL_IN_T4EXT, `PSL_IN_T6EXT, `PSL_IN_CAP1,
    `PSL_IN_CAP2,  `PSL_IN_CAP3,  `PSL_IN_CAP4,  `PSL_IN_MTWIN,
    `PSL_IN_MTSIG, `PSL_IN_WAVE1, `PSL_IN_WAVE2, `PSL_IN_MODCL,
    `PSL_IN_MODCH, `PSL_IN_MODSRC, `PSL_IN_LC0,  `PSL_IN_LC1,
    `PSL_IN_LC2,   `PSL_IN_LC3,   `PSL_IN_ADTRG, `PSL_IN_SPCLK,
    `PSL_IN_SPDAT, `PSL_IN_SPCS
  };

  // input select index of an address, NIN when none matches
  function automatic logic [5:0] in_index(
    input logic [`PSL_ADDR_W-1:0] a
  );
    logic [5:0] idx;
    idx = 6'(NIN);
    for (int k = 0; k < NIN; k++) begin
      if (a == IN_OFS[k]) begin
        idx = 6'(k);
      end
    end
    return idx;
  endfunction

  // output select index, valid only with out_hit
  function automatic logic [4:0] out_index(
    input logic [`PSL_ADDR_W-1:0] a
  );
    logic [`PSL_ADDR_W-1:0] d;
    d = a - `PSL_OUT_BASE;
    return d[4:0];
  endfunction


  // state
  //   selection flops sit beside the lock state they obey
  psl_key_t                key_reg;
  psl_key_t                key_next;
  logic                    lock_next;
  logic                    used_next;
  psl_insel_t              in_sel_reg [NIN];
  psl_outsel_t             out_sel_reg [NOUT];
  logic [23:0]             pin_meta_reg;
  logic [23:0]             pin_sync_reg;
  logic                    ow_meta_reg;
  logic                    ow_sync_reg;
  logic [1:0]              cfg_wait_reg;


  // address decode
  //   one byte register per address, absent ones never hit
  wire logic [5:0]  in_idx    = in_index(addr);
  wire logic        in_hit    = (in_idx != 6'(NIN));
  wire logic [4:0]  out_idx   = out_index(addr);
  wire logic [`PSL_ADDR_W-1:0] out_dist = addr - `PSL_OUT_BASE;
  wire logic        out_hit   = (addr >= `PSL_OUT_BASE) &&
                                (out_dist < `PSL_ADDR_W'(NOUT)) &&
                                OUT_PRESENT[out_idx];
  wire logic        lock_hit  = (addr == `PSL_LOCK_OFS);
  wire logic        wr_lock   = wr_en && lock_hit;
  wire logic        is_key1   = wr_lock && (wr_data == `PSL_KEY1);
  wire logic        is_key2   = wr_lock && (wr_data == `PSL_KEY2);

  // routing writes pass only while unlocked
  wire logic        route_ok  = wr_en && !lock_flag_reg;
  wire logic        in_wr     = route_ok && in_hit;
  wire logic        out_wr    = route_ok && out_hit;

  // a lock change needs the open key and, with one-way set, no
  // earlier completed clear-then-set since reset
  wire logic        allow_chg = !one_way_reg || !used_reg;
  wire logic        lock_wr   = wr_lock && (key_reg == PSL_KEY_OPEN)
                                && allow_chg;
  wire logic        new_lock  = wr_data[`PSL_LOCK_BIT];


  // key sequence: any write breaks a partial sequence, reads do not
  //   so a polling read between keys is harmless
  always_comb begin
    key_next = key_reg;
    if (wr_en) begin
      unique case (key_reg)
        PSL_KEY_IDLE: key_next = is_key1 ? PSL_KEY_HALF
                                         : PSL_KEY_IDLE;
        PSL_KEY_HALF: key_next = is_key2 ? PSL_KEY_OPEN
                               : is_key1 ? PSL_KEY_HALF
                                         : PSL_KEY_IDLE;
        PSL_KEY_OPEN: key_next = is_key1 ? PSL_KEY_HALF
                                         : PSL_KEY_IDLE;
      endcase
    end
  end

  // lock flag and one-way consumption record
  always_comb begin
    lock_next = lock_flag_reg;
    used_next = used_reg;
    if (lock_wr) begin
      lock_next = new_lock;
      // a set from the clear state spends the one-time allowance
      if (one_way_reg && new_lock && !lock_flag_reg) begin
        used_next = 1'b1;
      end
    end
  end

  // lock state; other device resets restart the lock handling too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_reg       <= PSL_KEY_IDLE;
      lock_flag_reg <= `PSL_LOCK_RST;
      used_reg      <= 1'b0;
    end else if (ce) begin
      if (sys_reset) begin
        key_reg       <= PSL_KEY_IDLE;
        lock_flag_reg <= `PSL_LOCK_RST;
        used_reg      <= 1'b0;
      end else begin
        key_reg       <= key_next;
        lock_flag_reg <= lock_next;
        used_reg      <= used_next;
      end
    end
  end


  // one-way option strap: synchronised, then caught after release
  //   later strap movement is ignored until the next power-on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ow_meta_reg  <= 1'b0;
      ow_sync_reg  <= 1'b0;
    end else if (ce) begin
      ow_meta_reg  <= one_way_pin;
      ow_sync_reg  <= ow_meta_reg;
    end
  end

  // wait lets the synchroniser fill before the strap is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_wait_reg <= `PSL_CFG_WAIT;
      one_way_reg  <= 1'b0;
    end else if (ce && cfg_wait_reg != 2'h0) begin
      cfg_wait_reg <= cfg_wait_reg - 2'h1;
      if (cfg_wait_reg == 2'h1) begin
        one_way_reg <= ow_sync_reg;
      end
    end
  end


  // selection registers: only power-on reset touches them, so
  // sys_reset and sleep deliberately have no path in here
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          in_sel_reg[gi] <= psl_insel_t'(IN_DEFAULT[gi*5 +: 5]);
        end else if (ce && in_wr && in_idx == 6'(gi)) begin
          in_sel_reg[gi] <= wr_data[4:0];
        end
      end
    end
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          out_sel_reg[gi] <= `PSL_OUT_RST;
        end else if (ce && out_wr && out_idx == 5'(gi)) begin
          out_sel_reg[gi] <= wr_data[`PSL_SRC_W-1:0];
        end
      end
    end
  endgenerate


  // read path: independent of lock and option state
  //   unmapped addresses fall through to zero
  wire logic [7:0] rd_in   = in_hit ?
    {3'h0, in_sel_reg[in_idx[4:0]]} : 8'h00;
  wire logic [7:0] rd_out  = out_hit ?
    {2'h0, out_sel_reg[out_idx]} : 8'h00;
  wire logic [7:0] rd_lock = lock_hit ?
    {7'h00, lock_flag_reg} : 8'h00;
  wire logic [7:0] rd_mux  = rd_in | rd_out | rd_lock;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
    end else if (ce) begin
      rd_data_reg <= rd_en ? rd_mux : 8'h00;
    end
  end


  // input crossbar: pins are asynchronous, two flops before use
  //   with the output flop, costs three cycles of latency on every routed input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 24'h000000;
      pin_sync_reg <= 24'h000000;
    end else if (ce) begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // port code picks the byte, pin code the bit; code 11 gives 0
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_xin
      wire logic [1:0] port_c =
        in_sel_reg[gi][`PSL_PORT_LSB +: `PSL_PORT_W];
      wire logic [2:0] pin_c  =
        in_sel_reg[gi][`PSL_PIN_LSB +: `PSL_PIN_W];
      wire logic       bit_v  = (port_c == `PSL_PORT_NONE) ? 1'b0 :
                                pin_sync_reg[{port_c, pin_c}];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          periph_in_reg[gi] <= 1'b0;
        end else if (ce) begin
          periph_in_reg[gi] <= bit_v;
        end
      end
    end
  endgenerate


  // output crossbar: code 0 leaves the pin to its port latch
  //   absent pins are never enabled, whatever the select holds
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_xout
      wire logic [`PSL_SRC_W-1:0] src_c = out_sel_reg[gi];
      wire logic use_v = OUT_PRESENT[gi] && (src_c != `PSL_OUT_RST);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_out_reg[gi]    <= 1'b0;
          pin_out_en_reg[gi] <= 1'b0;
        end else if (ce) begin
          pin_out_reg[gi]    <= use_v && periph_src[src_c];
          pin_out_en_reg[gi] <= use_v;
        end
      end
    end
  endgenerate

  // sleep only gates clocks elsewhere; selections hold regardless
  wire logic unused_ok = sleep;

endmodule

// ===== sim/psl_lock_ctrl_monitor.sv
// psl_lock_ctrl_monitor: port-level checks on the routing lock control
// assumes it is bound into psl_lock_ctrl, one clock, rst async active high
`timescale 1ns/100ps
`include "psl_defs.svh"
module psl_lock_ctrl_monitor
  import psl_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic                   sys_reset,
  input wire logic [`PSL_ADDR_W-1:0] addr,
  input wire logic [7:0]             wr_data,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire logic [7:0]             rd_data_reg,
  input wire logic                   lock_flag_reg,
  input wire logic                   one_way_reg,
  input wire logic                   used_reg,
  input wire logic [`PSL_OUT_CNT-1:0] pin_out_en_reg
);
  localparam logic [23:0] OUT_MASK =
    LARGE_PKG ? `PSL_OUT_MASK_LG : `PSL_OUT_MASK_SM;
  localparam logic [15:0] LOCK = `PSL_LOCK_OFS;

  // all checks are void while power-on reset is up
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // read data stands one cycle only, zero otherwise
  rd_idle_zero_a : assert property (
    ce && !rd_en |=> rd_data_reg == 8'h00)
    else $error("read data not zero outside a read reply");
  rd_lock_val_a : assert property (
    ce && rd_en && addr == LOCK |=>
      rd_data_reg == {7'h00, $past(lock_flag_reg)})
    else $error("lock register read wrong");
  rd_unmapped_a : assert property (
    ce && rd_en && addr == 16'h1E98 |=> rd_data_reg == 8'h00)
    else $error("unmapped read not zero");
  // flag moves only by a lock write or a device reset
  lock_rise_src_a : assert property (
    $rose(lock_flag_reg) |-> $past(ce && wr_en && addr == LOCK && wr_data[0]))
    else $error("lock flag set without a lock write");
  lock_fall_src_a : assert property (
    $fell(lock_flag_reg) |->
      $past(ce && (sys_reset || (wr_en && addr == LOCK && !wr_data[0]))))
    else $error("lock flag cleared without cause");
  one_way_hold_a : assert property (
    one_way_reg && used_reg && lock_flag_reg && !sys_reset |=> lock_flag_reg)
    else $error("lock flag cleared after one-way allowance spent");
  used_mark_a : assert property (
    $rose(used_reg) |-> $rose(lock_flag_reg) && $past(one_way_reg))
    else $error("allowance spent without a one-way lock");
  sys_reset_clr_a : assert property (
    ce && sys_reset |=> !lock_flag_reg && !used_reg)
    else $error("device reset left lock state set");
  out_absent_a : assert property (
    (pin_out_en_reg & ~OUT_MASK) == 24'h000000)
    else $error("absent pin driven by crossbar");

  // main scenarios reached
  lock_set_c : cover property ($rose(lock_flag_reg));
  used_set_c : cover property ($rose(used_reg));
  lock_read_c : cover property (ce && rd_en && addr == LOCK);
endmodule

bind psl_lock_ctrl psl_lock_ctrl_monitor #(.LARGE_PKG(LARGE_PKG)) mon (
  .clk(clk), .rst(rst), .ce(ce), .sys_reset(sys_reset), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_reg(rd_data_reg),
  .lock_flag_reg(lock_flag_reg), .one_way_reg(one_way_reg),
  .used_reg(used_reg), .pin_out_en_reg(pin_out_en_reg)
);

// ===== sim/tb.sv
// tb: self-checking bench for the routing lock control
// assumes psl_defs.svh on the include path; bench drives every port
`timescale 1ns/100ps
`include "psl_defs.svh"
module tb;
  import psl_pkg::*;
  // one bit per mapped input select from 0x1E90 upward
  localparam logic [55:0] IN_MAP = 56'hE87F06061E70FF;
  logic                   clk, rst, ce, sys_reset, sleep, one_way_pin;
  logic                   wr_en, rd_en, lock_flag_reg, one_way_reg, used_reg;
  logic [15:0]            addr;
  logic [7:0]             wr_data, rd_data_reg;
  logic [23:0]            pin_in, pin_out_reg, pin_out_en_reg;
  logic [63:0]            periph_src;
  logic [`PSL_IN_CNT-1:0] periph_in_reg;
  int                     fails, check_count;

  psl_lock_ctrl dut (
    .clk(clk), .rst(rst), .ce(ce), .sys_reset(sys_reset), .sleep(sleep),
    .one_way_pin(one_way_pin), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .pin_in(pin_in), .periph_src(periph_src),
    .rd_data_reg(rd_data_reg), .lock_flag_reg(lock_flag_reg),
    .one_way_reg(one_way_reg), .used_reg(used_reg),
    .periph_in_reg(periph_in_reg), .pin_out_reg(pin_out_reg),
    .pin_out_en_reg(pin_out_en_reg)
  );

  // free-running clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // step past edges so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chkb(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // reply stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check_count++;
    if (rd_data_reg !== e) begin
      fails++;
      $display("MISMATCH read %h expected %h seen %h", a, e, rd_data_reg);
    end
  endtask

  task automatic keys(input logic [7:0] v);
    wr(`PSL_LOCK_OFS, `PSL_KEY1);
    wr(`PSL_LOCK_OFS, `PSL_KEY2);
    wr(`PSL_LOCK_OFS, v);
    tick(0);
  endtask

  // strap must be steady from release; wait for its synchroniser
  task automatic por;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(3);
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    print_verdict;
  end

  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sys_reset = 1'b0;
    sleep = 1'b0;
    one_way_pin = 1'b0;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pin_in = '0;
    periph_src = '0;
    por;
    rd(`PSL_LOCK_OFS, 8'h00);
    rd(16'h1E98, 8'h00);
    for (int j = 0; j < 56; j++) begin
      if (IN_MAP[j]) begin
        rd(16'h1E90 + 16'(j), 8'h00);
        wr(16'h1E90 + 16'(j), {3'b111, 5'(j)});
        rd(16'h1E90 + 16'(j), {3'b000, 5'(j)});
      end
    end
    // walk every port and pin; index equals the select code
    for (int i = 0; i < 24; i++) begin
      wr(`PSL_IN_INT, {3'b000, 5'(i)});
      pin_in <= 24'h1 << i;
      tick(4);
      chkb("route_high", 1'b1, periph_in_reg[0]);
      @(posedge clk);
      pin_in <= ~(24'h1 << i);
      tick(4);
      chkb("route_low", 1'b0, periph_in_reg[0]);
    end
    wr(`PSL_IN_INT, 8'h1F);
    pin_in <= '1;
    tick(4);
    chkb("route_none", 1'b0, periph_in_reg[0]);
    wr(`PSL_OUT_BASE, 8'hC1);
    periph_src <= 64'h2;
    tick(2);
    chkb("out_en", 1'b1, pin_out_en_reg[0]);
    chkb("out_val", 1'b1, pin_out_reg[0]);
    rd(`PSL_OUT_BASE, 8'h01);
    wr(`PSL_OUT_BASE + 16'h3, 8'h01);
    rd(`PSL_OUT_BASE + 16'h3, 8'h00);
    chkb("out_gap", 1'b0, pin_out_en_reg[3]);
    // a foreign write between the keys discards them
    wr(`PSL_LOCK_OFS, `PSL_KEY1);
    wr(`PSL_IN_INT, 8'h1F);
    wr(`PSL_LOCK_OFS, `PSL_KEY2);
    wr(`PSL_LOCK_OFS, 8'h01);
    tick(0);
    chkb("lock_broken", 1'b0, lock_flag_reg);
    keys(8'hFF);
    chkb("lock_set", 1'b1, lock_flag_reg);
    rd(`PSL_LOCK_OFS, 8'h01);
    wr(`PSL_IN_INT, 8'h0A);
    wr(`PSL_OUT_BASE, 8'h02);
    sleep <= 1'b1;
    rd(`PSL_IN_INT, 8'h1F);
    rd(`PSL_OUT_BASE, 8'h01);
    @(posedge clk);
    sleep <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      keys(8'h00);
      chkb("lock_clear", 1'b0, lock_flag_reg);
      keys(8'h01);
      chkb("lock_again", 1'b1, lock_flag_reg);
    end
    keys(8'h00);
    wr(`PSL_IN_INT, 8'h0A);
    rd(`PSL_IN_INT, 8'h0A);
    keys(8'h01);
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    tick(1);
    chkb("sys_lock", 1'b0, lock_flag_reg);
    rd(`PSL_IN_INT, 8'h0A);
    @(posedge clk);
    one_way_pin <= 1'b1;
    por;
    rd(`PSL_IN_INT, 8'h00);
    keys(8'h01);
    chkb("used_set", 1'b1, used_reg);
    keys(8'h00);
    chkb("one_way_held", 1'b1, lock_flag_reg);
    por;
    chkb("used_clear", 1'b0, used_reg);
    keys(8'h01);
    keys(8'h00);
    chkb("one_way_again", 1'b1, lock_flag_reg);
    print_verdict;
  end
endmodule
